// *** pkg/acm_pkg.sv ***
// Shared constants and carrier types for the analog configuration command decoder
package acm_pkg;

	// ----------------------------------------
	// Command opcodes and frame layout
	// ----------------------------------------
	localparam logic [7:0] OP_LOAD_PIN_VOL = 8'h45;   // load_config_pin_volume
	localparam logic [7:0] OP_LOAD_BIT_VOL = 8'h65;   // load_config_bit_volume
	localparam logic [7:0] OP_PERSIST      = 8'h46;   // persist_config
	localparam logic [7:0] OP_RESTORE      = 8'h47;   // restore_config
	localparam logic [7:0] COPY_ARG        = 8'h00;   // Second byte of the copy commands
	localparam logic [1:0] LOAD_BYTES      = 2'h3;    // Bytes in a load frame
	localparam logic [1:0] COPY_BYTES      = 2'h2;    // Bytes in a copy frame
	localparam logic [2:0] LAST_BIT        = 3'h7;    // Index of the last bit of a byte

	// ----------------------------------------
	// Configuration word layout
	// ----------------------------------------
	localparam int CFG_W      = 12;                   // Width of analog_path_config
	localparam int HI_NIB_W   = 4;                    // Useful bits of the third byte
	localparam int VOL_W      = 3;                    // Volume field width, bits 2..0
	localparam logic [CFG_W-1:0] NV_DEFAULT = 12'h000; // Store contents at power-on

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam int ADDR_W = 5;                        // Register address width
	localparam int DATA_W = 16;                       // Register data width
	localparam logic [ADDR_W-1:0] REG_STATUS  = 5'h00; // Sticky events, cleared by read
	localparam logic [ADDR_W-1:0] REG_MASK    = 5'h04; // Interrupt mask
	localparam logic [ADDR_W-1:0] REG_CONFIG  = 5'h08; // Live configuration, read only
	localparam logic [ADDR_W-1:0] REG_PERSIST = 5'h0c; // Persistent copy, read only

	// ----------------------------------------
	// Status bit positions and reset values
	// ----------------------------------------
	localparam int ST_W       = 4;                    // Number of status bits
	localparam int ST_LOAD    = 0;                    // A load command completed
	localparam int ST_PERSIST = 1;                    // A persist command completed
	localparam int ST_RESTORE = 2;                    // A restore command completed
	localparam int ST_CMD_ERR = 3;                    // Copy refused while busy
	localparam int CFG_SRC_BIT = 12;                  // Volume source bit in REG_CONFIG
	localparam logic [ST_W-1:0]  MASK_RESET = 4'h0;   // All interrupts masked at reset
	localparam logic [VOL_W-1:0] PIN_VOL_RESET = 3'h0; // Pin-stepped level after reset

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;                      // Byte address
		logic [DATA_W-1:0] wdata;                     // Write data
		logic              wr;                        // Write strobe
		logic              rd;                        // Read strobe
	} acm_bus_req_t;

	typedef struct packed {
		logic [7:0] opcode;                           // First byte of the frame
		logic [7:0] arg1;                             // Second byte
		logic [7:0] arg2;                             // Third byte
		logic [1:0] count;                            // Whole bytes seen, saturating
	} acm_frame_t;

endpackage : acm_pkg

// *** core/acm_sync.sv ***
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module acm_sync #(
	parameter int W = 1                               // Number of bits synchronised
) (
	input  wire logic         clk,                    // System clock
	input  wire logic         sys_rst,                // Synchronous reset, active high
	input  wire logic [W-1:0] rst_val,                // Level held during reset
	input  wire logic [W-1:0] async_in,               // Pins from outside the domain
	output logic      [W-1:0] sync_out                // Synchronised copy
);

	logic [W-1:0] stage1;                             // First stage, read only by stage 2

	// Two stages; only the second is visible outside
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage1   <= rst_val;
			sync_out <= rst_val;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : acm_sync
`default_nettype wire

// *** core/acm_core.sv ***
// Analog configuration command decoder with persistent copy and register port
`timescale 1ns/1ps
`default_nettype none
module acm_core
	import acm_pkg::*;
#(
	parameter logic [CFG_W-1:0] NV_INIT = NV_DEFAULT,  // Store contents at power-on
	parameter bit               LSB_FIRST = 1'b1       // Serial bit order on the link
) (
	input  wire logic              clk,                // System clock, 200 MHz
	input  wire logic              sys_rst,            // Device reset, synchronous
	input  wire logic              pwr_on_rst,         // Power-on reset, synchronous
	input  wire logic              spi_sclk,           // Serial clock pin
	input  wire logic              spi_ss_n,           // Slave select pin, active low
	input  wire logic              spi_mosi,           // Serial data in pin
	input  wire logic              loudness_select_pin_n, // Volume step button, active low
	input  wire logic              device_idle,        // High while no command runs
	input  wire acm_bus_req_t      bus_req,            // Register port request
	output logic      [DATA_W-1:0] rd_data,            // Read data, cycle after strobe
	output logic      [CFG_W-1:0]  analog_path_config, // Live configuration
	output logic      [CFG_W-1:0]  persistent_config_copy, // Non-volatile copy
	output logic      [VOL_W-1:0]  volume_level,       // Effective volume level
	output logic                   volume_from_pin,    // Volume source is the pin
	output logic                   cmd_err,            // Command error flag
	output logic                   irq                 // Level interrupt
);

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	logic [3:0] pins_s;                                // Synchronised pins
	logic       sck_s;                                 // Serial clock, synced
	logic       ss_n_s;                                // Select, synced
	logic       mosi_s;                                // Data, synced
	logic       vol_n_s;                               // Volume button, synced

	acm_sync #(
		.W        (4)
	) u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.rst_val  (4'h7),
		.async_in ({spi_sclk, spi_ss_n, loudness_select_pin_n, spi_mosi}),
		.sync_out (pins_s)
	);

	assign sck_s   = pins_s[3];
	assign ss_n_s  = pins_s[2];
	assign vol_n_s = pins_s[1];
	assign mosi_s  = pins_s[0];

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	logic sck_prev;                                    // Serial clock last cycle
	logic ss_prev;                                     // Select last cycle
	logic vol_prev;                                    // Button last cycle
	logic sck_rise;                                    // Sampling edge inside a frame
	logic frame_start;                                 // Select just asserted
	logic frame_end;                                   // Select just released
	logic vol_press;                                   // Button just pressed

	// Reset levels match the idle pins, so leaving reset fakes no edge
	// Previous levels of the synchronised pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_prev <= 1'b0;
			ss_prev  <= 1'b1;
			vol_prev <= 1'b1;
		end else begin
			sck_prev <= sck_s;
			ss_prev  <= ss_n_s;
			vol_prev <= vol_n_s;
		end
	end

	assign sck_rise    = sck_s & ~sck_prev & ~ss_n_s;
	assign frame_start = ~ss_n_s & ss_prev;
	assign frame_end   = ss_n_s & ~ss_prev;
	assign vol_press   = ~vol_n_s & vol_prev;

	// ----------------------------------------
	// Byte assembly
	// ----------------------------------------
	logic [2:0] bit_cnt;                               // Bit index within the byte
	logic [7:0] shift;                                 // Partial byte
	logic [7:0] next_byte;                             // Byte completed by this bit
	acm_frame_t frame;                                 // Bytes of the current frame

	assign next_byte = LSB_FIRST ? {mosi_s, shift[7:1]} : {shift[6:0], mosi_s};

	// Shift register and bit counter, restarted at each select
	always_ff @(posedge clk) begin
		if (sys_rst || frame_start) begin
			bit_cnt <= 3'h0;
			shift   <= 8'h00;
		end else if (sck_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			shift   <= next_byte;
		end
	end

	// Store whole bytes by position; later bytes are dropped
	// Bytes past the third still clock the counter but are never kept
	always_ff @(posedge clk) begin
		if (sys_rst || frame_start) begin
			frame <= '0;
		end else if (sck_rise && bit_cnt == LAST_BIT) begin
			unique case (frame.count)
				2'h0: frame.opcode <= next_byte;
				2'h1: frame.arg1   <= next_byte;
				2'h2: frame.arg2   <= next_byte;
				2'h3: ;
			endcase
			if (frame.count != 2'h3) begin
				frame.count <= frame.count + 2'h1;
			end
		end
	end

	// ----------------------------------------
	// Command decode at deselect
	// ----------------------------------------
	logic is_load_pin;                                 // Complete pin-volume load
	logic is_load_bit;                                 // Complete bit-volume load
	logic is_copy;                                     // Second byte is the copy argument
	logic do_load;                                     // Commit a load
	logic do_persist;                                  // Commit a persist
	logic do_restore;                                  // Commit a restore
	logic copy_refused;                                // Copy seen while busy

	// Nothing is judged until select goes high, so a frame that the host
	// abandons part way leaves every register as it was
	// Decide whether a frame carries a given command with enough bytes
	function automatic logic frame_is(input acm_frame_t f, input logic [7:0] op, input logic [1:0] n);
		frame_is = (f.opcode == op) && (f.count >= n) && (f.count != 2'h0);
	endfunction : frame_is

	assign is_load_pin  = frame_is(frame, OP_LOAD_PIN_VOL, LOAD_BYTES);
	assign is_load_bit  = frame_is(frame, OP_LOAD_BIT_VOL, LOAD_BYTES);
	assign is_copy      = frame.arg1 == COPY_ARG;
	assign do_load      = frame_end && (is_load_pin || is_load_bit);
	assign do_persist   = frame_end && is_copy && device_idle
	                      && frame_is(frame, OP_PERSIST, COPY_BYTES);
	assign do_restore   = frame_end && is_copy && device_idle
	                      && frame_is(frame, OP_RESTORE, COPY_BYTES);
	assign copy_refused = frame_end && is_copy && !device_idle
	                      && (frame_is(frame, OP_PERSIST, COPY_BYTES)
	                      || frame_is(frame, OP_RESTORE, COPY_BYTES));

	// ----------------------------------------
	// Persistent store and live configuration
	// ----------------------------------------
	// Store survives device reset; only power-on and a persist write it
	// The non-volatile cell is modelled as a register kept out of sys_rst
	always_ff @(posedge clk) begin
		if (pwr_on_rst) begin
			persistent_config_copy <= NV_INIT;
		end else if (do_persist) begin
			persistent_config_copy <= analog_path_config;
		end
	end

	// Live configuration: NV_INIT at power-on, reloaded from the store on device reset
	always_ff @(posedge clk) begin
		if (pwr_on_rst) begin
			analog_path_config <= NV_INIT;
		end else if (sys_rst) begin
			analog_path_config <= persistent_config_copy;
		end else if (do_load) begin
			analog_path_config <= {frame.arg2[HI_NIB_W-1:0], frame.arg1};
		end else if (do_restore) begin
			analog_path_config <= persistent_config_copy;
		end
	end

	// Volume source chosen by the last load opcode
	always_ff @(posedge clk) begin
		if (sys_rst || pwr_on_rst) begin
			volume_from_pin <= 1'b0;
		end else if (do_load) begin
			volume_from_pin <= is_load_pin;
		end
	end

	// ----------------------------------------
	// Volume level
	// ----------------------------------------
	logic [VOL_W-1:0] pin_level;                       // Level stepped by the button

	// The button level runs on while the bits are selected, so a later
	// pin-volume load picks up the present button position
	// Each button press steps the level, wrapping at the top
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_level <= PIN_VOL_RESET;
		end else if (vol_press) begin
			pin_level <= pin_level + 3'h1;
		end
	end

	// Effective level from the selected source
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			volume_level <= PIN_VOL_RESET;
		end else if (volume_from_pin) begin
			volume_level <= pin_level;
		end else begin
			volume_level <= analog_path_config[VOL_W-1:0];
		end
	end

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------
	logic [ST_W-1:0] status;                           // Sticky event bits
	logic [ST_W-1:0] mask;                             // Interrupt enables
	logic [ST_W-1:0] st_set;                           // Events this cycle
	logic            st_read;                          // Status read clears

	assign st_set  = {copy_refused, do_restore, do_persist, do_load};
	assign st_read = bus_req.rd && (bus_req.addr == REG_STATUS);

	// Read clears, a same-cycle event still wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status <= '0;
		end else begin
			status <= (status & ~({ST_W{st_read}})) | st_set;
		end
	end

	// Writes to any other address, the read-only ones too, are dropped
	// Mask register written over the port
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mask <= MASK_RESET;
		end else if (bus_req.wr && bus_req.addr == REG_MASK) begin
			mask <= bus_req.wdata[ST_W-1:0];
		end
	end

	assign irq     = |(status & mask);
	assign cmd_err = status[ST_CMD_ERR];

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (sys_rst || !bus_req.rd) begin
			rd_data <= '0;
		end else begin
			unique case (bus_req.addr)
				REG_STATUS:  rd_data <= {{(DATA_W-ST_W){1'b0}}, status};
				REG_MASK:    rd_data <= {{(DATA_W-ST_W){1'b0}}, mask};
				REG_CONFIG:  rd_data <= {3'h0, volume_from_pin, analog_path_config};
				REG_PERSIST: rd_data <= {4'h0, persistent_config_copy};
				default:     rd_data <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Each check but reset_reload_a is disabled through either reset; reset_reload_a only through pwr_on_rst
	cfg_load_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		(frame_end && is_load_bit) |=> analog_path_config == {$past(frame.arg2[3:0]), $past(frame.arg1)})
		else $error("load did not store the frame bytes");

	high_bits_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		do_load |=> analog_path_config[11:8] == $past(frame.arg2[3:0]))
		else $error("third byte upper bits leaked into config");

	pin_volume_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		(frame_end && is_load_pin) |=> volume_from_pin ##1 volume_level == $past(pin_level))
		else $error("pin volume load did not select the pin");

	bit_volume_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		(frame_end && is_load_bit) |=> !volume_from_pin ##1 volume_level == $past(analog_path_config[2:0]))
		else $error("bit volume load did not use bits 2..0");

	persist_copy_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		do_persist |=> persistent_config_copy == $past(analog_path_config) && status[ST_PERSIST])
		else $error("persist did not copy config");

	reset_reload_a: assert property (@(posedge clk) disable iff (pwr_on_rst)
		sys_rst |=> analog_path_config == $past(persistent_config_copy))
		else $error("reset did not reload config from store");

	restore_load_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		do_restore |=> analog_path_config == $past(persistent_config_copy))
		else $error("restore did not load config");

	busy_error_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		copy_refused |=> cmd_err && $stable(persistent_config_copy) && $stable(analog_path_config))
		else $error("busy copy was not refused");

	short_frame_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		(!frame_end || frame.count < LOAD_BYTES) && !do_restore |=> $stable(analog_path_config))
		else $error("config changed without a complete frame");

	load_flag_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		do_load |=> status[ST_LOAD])
		else $error("load did not raise its status bit");

	source_hold_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		!do_load |=> $stable(volume_from_pin))
		else $error("volume source changed without a load");

	pin_step_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		vol_press |=> pin_level == $past(pin_level) + 3'h1)
		else $error("button press did not step the pin level");

	store_hold_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		!do_persist |=> $stable(persistent_config_copy))
		else $error("store changed without a persist");

	restore_flag_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		do_restore |=> status[ST_RESTORE])
		else $error("restore did not raise its status bit");

	idle_no_err_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		device_idle |=> !$rose(cmd_err))
		else $error("command error raised while idle");

	err_sticky_a: assert property (@(posedge clk) disable iff (sys_rst || pwr_on_rst)
		cmd_err && !st_read |=> cmd_err)
		else $error("command error cleared without a read");

endmodule : acm_core
`default_nettype wire

// *** verification/acm_spi_host.sv ***
// SPI host model that sends command frames to the decoder
`timescale 1ns/1ps
`default_nettype none
module acm_spi_host (
	input  wire logic        clk,    // System clock
	input  wire logic        start,  // Begin a frame
	input  wire logic [1:0]  nbytes, // Whole bytes in the frame
	input  wire logic [23:0] frame,  // Byte 0 in bits 7..0
	input  wire logic [2:0]  half,   // Clock cycles per serial phase
	output logic             sclk,   // Serial clock, still between frames
	output logic             ss_n,   // Select, active low
	output logic             mosi,   // Serial data
	output logic             busy    // Frame in flight
);
	int i; // Bit counter

	// ----------------------------------------
	// Frame sequencer: select, bits LSB first in mode 0, deselect
	// ----------------------------------------
	// One process owns every output: idle levels first, then frames on request
	initial begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (start) begin
				busy <= 1'b1;
				ss_n <= 1'b0;
				for (i = 0; i < 8 * nbytes; i++) begin
					mosi <= frame[i];
					repeat (half) @(posedge clk);
					sclk <= 1'b1;
					repeat (half) @(posedge clk);
					sclk <= 1'b0;
				end
				repeat (half) @(posedge clk);
				ss_n <= 1'b1;
				// Released line must not keep showing the last bit
				mosi <= ~mosi;
				busy <= 1'b0;
			end
		end
	end
endmodule : acm_spi_host
`default_nettype wire

// *** verification/acm_core_tb.sv ***
// Self-checking bench for the analog configuration command decoder
`timescale 1ns/1ps
`default_nettype none
module acm_core_tb
	import acm_pkg::*;
;
	localparam logic [CFG_W-1:0] NV_SEED = 12'h5a3; // Store contents at power-on

	logic              clk = 1'b0;               // Bench clock, toggled by one process only
	logic              sys_rst, pwr_on_rst, pin_n, device_idle;
	acm_bus_req_t      bus_req;                  // Register port request
	logic [DATA_W-1:0] rd_data, d;               // Read data and bench copy
	logic [CFG_W-1:0]  cfg, store, exp_cfg, exp_store;
	logic [VOL_W-1:0]  loudness_select_pin, exp_vol, pin_lvl;    // Volume seen, expected, pin steps
	logic              from_pin, cmd_err, irq, exp_pin, vol_known;
	logic              sclk, ss_n, mosi, host_busy, start;
	logic [1:0]        nbytes;
	logic [23:0]       frame;
	logic [2:0]        half;
	logic [15:0]       rnd;                      // Random source
	logic [7:0]        b1, b2;
	int                mismatches, compares, k;

	acm_core #(.NV_INIT(NV_SEED), .LSB_FIRST(1'b1)) dut (
		.clk(clk), .sys_rst(sys_rst), .pwr_on_rst(pwr_on_rst), .spi_sclk(sclk), .spi_ss_n(ss_n),
		.spi_mosi(mosi), .loudness_select_pin_n(pin_n), .device_idle(device_idle), .bus_req(bus_req),
		.rd_data(rd_data), .analog_path_config(cfg), .persistent_config_copy(store),
		.volume_level(loudness_select_pin), .volume_from_pin(from_pin), .cmd_err(cmd_err), .irq(irq));

	acm_spi_host host (.clk(clk), .start(start), .nbytes(nbytes), .frame(frame), .half(half),
		.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .busy(host_busy));

	// Clock of 5 ns period
	always #2.5 clk = ~clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Third byte keeps only its low nibble
	function automatic logic [11:0] cfg_of(input logic [7:0] lo, input logic [7:0] hi);
		return {hi[3:0], lo};
	endfunction : cfg_of

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		d = rd_data;
		check(d, exp);
	endtask : rd_chk

	// Volume stepped only while no frame is in flight
	task automatic step_pin;
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		pin_n <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		pin_lvl = pin_lvl + 3'h1;
	endtask : step_pin

	// One frame through the host model, with a random serial rate
	task automatic send(input logic [1:0] nb, input logic [23:0] fr);
		int n;
		@(posedge clk);
		start <= 1'b1;
		nbytes <= nb;
		frame <= fr;
		half <= 3'h3 + {1'b0, rnd[1:0]};
		rnd = lfsr(rnd);
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		for (n = 0; n < 2000 && host_busy === 1'b1; n++) @(posedge clk);
		if (host_busy === 1'b1) begin
			mismatches++;                        // Host never finished the frame
		end
		repeat (8) @(posedge clk);
		#1;
	endtask : send

	task automatic check_state;
		check({4'h0, cfg}, {4'h0, exp_cfg});
		check({4'h0, store}, {4'h0, exp_store});
		if (vol_known) begin
			check({12'h0, from_pin, loudness_select_pin}, {12'h0, exp_pin, exp_vol});
		end
	endtask : check_state

	task automatic load(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
		send(2'h3, {hi, lo, op});
		exp_cfg = cfg_of(lo, hi);
		exp_pin = (op == OP_LOAD_PIN_VOL);
		exp_vol = exp_pin ? pin_lvl : lo[2:0];
		vol_known = 1'b1;
		check_state();
	endtask : load

	// ----------------------------------------
	// Watchdog against a hang
	// ----------------------------------------
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		complete_run();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		pwr_on_rst = 1'b1;
		pin_n = 1'b1;
		device_idle = 1'b1;
		bus_req = '0;
		start = 1'b0;
		nbytes = 2'h0;
		frame = 24'h000000;
		half = 3'h3;
		rnd = 16'h001f;
		mismatches = 0;
		compares = 0;
		pin_lvl = 3'h0;
		exp_cfg = NV_SEED;
		exp_store = NV_SEED;
		exp_pin = 1'b0;
		exp_vol = 3'h0;
		vol_known = 1'b0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		pwr_on_rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check_state();
		// Mask is read-write, an unmapped place reads zero, read-only REG_CONFIG refuses writes
		wr_reg(REG_MASK, 16'hfff8);
		rd_chk(REG_MASK, 16'h0008);
		rd_chk(5'h1c, 16'h0000);
		wr_reg(REG_CONFIG, 16'hffff);
		rd_chk(REG_CONFIG, {4'h0, NV_SEED});
		// Corner: all ignored high bits set, then random loads of both kinds
		load(OP_LOAD_BIT_VOL, 8'hff, 8'hf5);
		for (k = 0; k < 6; k++) begin
			step_pin();
			b1 = rnd[7:0];
			b2 = rnd[15:8];
			rnd = lfsr(rnd);
			load(k[0] ? OP_LOAD_PIN_VOL : OP_LOAD_BIT_VOL, b1, b2);
		end
		rd_chk(REG_STATUS, 16'h0001);
		rd_chk(REG_STATUS, 16'h0000);
		rd_chk(REG_CONFIG, {3'h0, exp_pin, exp_cfg});
		// Persist, overwrite, restore
		send(2'h2, {COPY_ARG, OP_PERSIST});
		exp_store = exp_cfg;
		check_state();
		rd_chk(REG_PERSIST, {4'h0, exp_store});
		load(OP_LOAD_BIT_VOL, 8'h5c, 8'h0e);
		send(2'h2, {COPY_ARG, OP_RESTORE});
		exp_cfg = exp_store;
		exp_vol = exp_store[VOL_W-1:0];
		check_state();
		rd_chk(REG_STATUS, 16'h0007);
		// Bad copy argument and short load are dropped
		send(2'h2, {8'h01, OP_PERSIST});
		send(2'h2, {8'h33, OP_LOAD_BIT_VOL});
		check_state();
		rd_chk(REG_STATUS, 16'h0000);
		// Copies while busy raise the error and the interrupt instead
		load(OP_LOAD_BIT_VOL, 8'h96, 8'h02);
		rd_chk(REG_STATUS, 16'h0001);
		@(posedge clk);
		device_idle <= 1'b0;
		send(2'h2, {COPY_ARG, OP_PERSIST});
		send(2'h2, {COPY_ARG, OP_RESTORE});
		check_state();
		check({14'h0, cmd_err, irq}, 16'h0003);
		@(posedge clk);
		device_idle <= 1'b1;
		rd_chk(REG_STATUS, 16'h0008);
		check({14'h0, cmd_err, irq}, 16'h0000);
		// Mid-run reset reloads the live configuration from the store
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		exp_cfg = exp_store;
		exp_pin = 1'b0;
		exp_vol = exp_store[VOL_W-1:0];
		pin_lvl = 3'h0;
		check_state();
		step_pin();
		load(OP_LOAD_PIN_VOL, 8'h07, 8'h0f);
		complete_run();
	end
endmodule : acm_core_tb
`default_nettype wire
